// ===== jid_instr_decode.sv
// Test-port instruction decoder with boundary chain and core selects
`timescale 1ns/1ps
module jid_instr_decode
(
    // System clock domain
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Test port pins
    input  wire logic       TEST_CLOCK_PIN,
    input  wire logic       TEST_MODE_SELECT_PIN,
    input  wire logic       TEST_DATA_IN_PIN,
    output logic            TEST_DATA_OUT_PIN,
    output logic            TEST_DATA_OUT_OE,
    // Device pins and core side
    input  wire logic [7:0] PIN_IN,
    output logic      [7:0] PIN_OUT,
    input  wire logic [7:0] CORE_OUT,
    output logic      [7:0] CORE_IN,
    // Core debug access, test clock domain
    input  wire logic       CORE_TDR_SO,
    output logic            TAP_CAPTURE_DR_ST,
    output logic            TAP_SHIFT_DR_ST,
    output logic            TAP_UPDATE_DR_ST,
    output logic            SEL_DEBUG_RECEIVE_ACCESS,
    output logic            SEL_ICACHE_LOAD_ACCESS,
    output logic            SEL_DEBUG_CTRL_STATUS_ACCESS,
    output logic            SEL_CORE_SELF_TEST,
    output logic            SNAPSHOT_MODE_ENTRY
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic jid_is_chain(input logic [6:0] code);
        jid_is_chain = (code == jid_pkg::OP_EXTERNAL_PIN_TEST) ||
                       (code == jid_pkg::OP_PIN_SNAPSHOT_PRELOAD); // RULE_01
    endfunction

    function automatic logic jid_is_core(input logic [6:0] code);
        jid_is_core = (code == jid_pkg::OP_DEBUG_RECEIVE_ACCESS) ||
                      (code == jid_pkg::OP_ICACHE_LOAD_ACCESS) ||
                      (code == jid_pkg::OP_DEBUG_CTRL_STATUS) ||
                      (code == jid_pkg::OP_CORE_SELF_TEST) ||
                      (code == jid_pkg::OP_SNAPSHOT_MODE_ENTRY); // RULE_01
    endfunction

    // ------------------------------------------------------------
    // State of the three clocking regions
    // ------------------------------------------------------------
    typedef struct packed {
        jid_pkg::jid_tap_t st;
        logic [6:0]        ir_sh;
        logic [15:0]       bsr_sh;
        logic              byp;
        logic [7:0]        pin_s1;
        logic [7:0]        pin_s2;
        logic [7:0]        core_s1;
        logic [7:0]        core_s2;
        logic              cap_dr;
        logic              shf_dr;
        logic              upd_dr;
    } jid_rise_t;

    typedef struct packed {
        logic [6:0] ir_cur;
        logic [7:0] latch;
        logic       tdo;
        logic       tdo_oe;
        logic       ext;
        logic       upd_tgl;
        logic [4:0] sel;
    } jid_fall_t;

    typedef struct packed {
        logic       ext_s1;
        logic       ext_s2;
        logic       tgl_s1;
        logic       tgl_s2;
        logic       tgl_s3;
        logic [7:0] latch_cap;
        logic [7:0] pin_out;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic [7:0] core_in;
    } jid_sys_t;

    jid_rise_t r_reg, r_next;
    jid_fall_t f_reg, f_next;
    jid_sys_t  c_reg, c_next;

    logic tck;
    logic tms;
    logic tdi;
    assign tck = TEST_CLOCK_PIN;
    assign tms = TEST_MODE_SELECT_PIN;
    assign tdi = TEST_DATA_IN_PIN;

    // ------------------------------------------------------------
    // Rising test clock: controller, capture and shift
    // ------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        r_next.pin_s1  = PIN_IN;
        r_next.pin_s2  = r_reg.pin_s1;
        r_next.core_s1 = CORE_OUT;
        r_next.core_s2 = r_reg.core_s1;
        case (r_reg.st)
            jid_pkg::TAP_RESET:      r_next.st = tms ? jid_pkg::TAP_RESET : jid_pkg::TAP_IDLE;
            jid_pkg::TAP_IDLE:       r_next.st = tms ? jid_pkg::TAP_SEL_DR : jid_pkg::TAP_IDLE;
            jid_pkg::TAP_SEL_DR:     r_next.st = tms ? jid_pkg::TAP_SEL_IR : jid_pkg::TAP_CAPTURE_DR;
            jid_pkg::TAP_CAPTURE_DR: r_next.st = tms ? jid_pkg::TAP_EXIT1_DR : jid_pkg::TAP_SHIFT_DR;
            jid_pkg::TAP_SHIFT_DR:   r_next.st = tms ? jid_pkg::TAP_EXIT1_DR : jid_pkg::TAP_SHIFT_DR;
            jid_pkg::TAP_EXIT1_DR:   r_next.st = tms ? jid_pkg::TAP_UPDATE_DR : jid_pkg::TAP_PAUSE_DR;
            jid_pkg::TAP_PAUSE_DR:   r_next.st = tms ? jid_pkg::TAP_EXIT2_DR : jid_pkg::TAP_PAUSE_DR;
            jid_pkg::TAP_EXIT2_DR:   r_next.st = tms ? jid_pkg::TAP_UPDATE_DR : jid_pkg::TAP_SHIFT_DR;
            jid_pkg::TAP_UPDATE_DR:  r_next.st = tms ? jid_pkg::TAP_SEL_DR : jid_pkg::TAP_IDLE;
            jid_pkg::TAP_SEL_IR:     r_next.st = tms ? jid_pkg::TAP_RESET : jid_pkg::TAP_CAPTURE_IR;
            jid_pkg::TAP_CAPTURE_IR: r_next.st = tms ? jid_pkg::TAP_EXIT1_IR : jid_pkg::TAP_SHIFT_IR;
            jid_pkg::TAP_SHIFT_IR:   r_next.st = tms ? jid_pkg::TAP_EXIT1_IR : jid_pkg::TAP_SHIFT_IR;
            jid_pkg::TAP_EXIT1_IR:   r_next.st = tms ? jid_pkg::TAP_UPDATE_IR : jid_pkg::TAP_PAUSE_IR;
            jid_pkg::TAP_PAUSE_IR:   r_next.st = tms ? jid_pkg::TAP_EXIT2_IR : jid_pkg::TAP_PAUSE_IR;
            jid_pkg::TAP_EXIT2_IR:   r_next.st = tms ? jid_pkg::TAP_UPDATE_IR : jid_pkg::TAP_SHIFT_IR;
            jid_pkg::TAP_UPDATE_IR:  r_next.st = tms ? jid_pkg::TAP_SEL_DR : jid_pkg::TAP_IDLE;
            default:                 r_next.st = jid_pkg::TAP_RESET;
        endcase
        // Instruction shifter
        if (r_reg.st == jid_pkg::TAP_CAPTURE_IR)
            r_next.ir_sh = jid_pkg::IR_CAPTURE_PATTERN; // RULE_13
        else if (r_reg.st == jid_pkg::TAP_SHIFT_IR)
            r_next.ir_sh = {tdi, r_reg.ir_sh[6:1]};
        // Data registers; only the selected one moves
        if (r_reg.st == jid_pkg::TAP_CAPTURE_DR)
        begin
            if (jid_is_chain(f_reg.ir_cur))
                r_next.bsr_sh = {r_reg.core_s2, r_reg.pin_s2}; // RULE_04 RULE_06
            else if (!jid_is_core(f_reg.ir_cur))
                r_next.byp = 1'b0; // RULE_16
        end
        else if (r_reg.st == jid_pkg::TAP_SHIFT_DR)
        begin
            if (jid_is_chain(f_reg.ir_cur))
                r_next.bsr_sh = {tdi, r_reg.bsr_sh[15:1]}; // RULE_02
            else if (!jid_is_core(f_reg.ir_cur))
                r_next.byp = tdi; // RULE_16
        end
        r_next.cap_dr = (r_next.st == jid_pkg::TAP_CAPTURE_DR);
        r_next.shf_dr = (r_next.st == jid_pkg::TAP_SHIFT_DR);
        r_next.upd_dr = (r_next.st == jid_pkg::TAP_UPDATE_DR);
    end

    always_ff @(posedge tck or negedge RST_N)
    begin
        if (!RST_N)
        begin
            r_reg        <= '0;
            r_reg.st     <= jid_pkg::TAP_RESET;
            r_reg.ir_sh  <= jid_pkg::IR_RESET_VALUE;
            r_reg.bsr_sh <= jid_pkg::CHAIN_RESET;
        end
        else
            r_reg <= r_next;
    end

    // ------------------------------------------------------------
    // Falling test clock: instruction latch, pin latches, data out
    // ------------------------------------------------------------
    always_comb
    begin
        f_next = f_reg;
        if (r_reg.st == jid_pkg::TAP_RESET)
            f_next.ir_cur = jid_pkg::IR_RESET_VALUE;
        else if (r_reg.st == jid_pkg::TAP_UPDATE_IR)
            f_next.ir_cur = r_reg.ir_sh; // RULE_14
        // Latches stay put while shifting, so pins never ripple
        if ((r_reg.st == jid_pkg::TAP_UPDATE_DR) && jid_is_chain(f_reg.ir_cur))
        begin
            f_next.latch   = r_reg.bsr_sh[15:8]; // RULE_07 RULE_15
            f_next.upd_tgl = ~f_reg.upd_tgl;
        end
        f_next.ext = (f_next.ir_cur == jid_pkg::OP_EXTERNAL_PIN_TEST);
        f_next.sel[0] = (f_next.ir_cur == jid_pkg::OP_DEBUG_RECEIVE_ACCESS); // RULE_08
        f_next.sel[1] = (f_next.ir_cur == jid_pkg::OP_ICACHE_LOAD_ACCESS); // RULE_09
        f_next.sel[2] = (f_next.ir_cur == jid_pkg::OP_DEBUG_CTRL_STATUS); // RULE_10
        f_next.sel[3] = (f_next.ir_cur == jid_pkg::OP_CORE_SELF_TEST); // RULE_11
        f_next.sel[4] = (f_next.ir_cur == jid_pkg::OP_SNAPSHOT_MODE_ENTRY); // RULE_12
        f_next.tdo_oe = (r_reg.st == jid_pkg::TAP_SHIFT_IR) ||
                        (r_reg.st == jid_pkg::TAP_SHIFT_DR);
        if (r_reg.st == jid_pkg::TAP_SHIFT_IR)
            f_next.tdo = r_reg.ir_sh[0];
        else if (jid_is_chain(f_reg.ir_cur))
            f_next.tdo = r_reg.bsr_sh[0];
        else if (jid_is_core(f_reg.ir_cur))
            f_next.tdo = CORE_TDR_SO;
        else
            f_next.tdo = r_reg.byp; // RULE_16
    end

    always_ff @(negedge tck or negedge RST_N)
    begin
        if (!RST_N)
        begin
            f_reg        <= '0;
            f_reg.ir_cur <= jid_pkg::IR_RESET_VALUE;
            f_reg.latch  <= jid_pkg::PIN_RESET;
        end
        else
            f_reg <= f_next;
    end

    // ------------------------------------------------------------
    // System clock: pin drive and core input
    // ------------------------------------------------------------
    // Latch word is taken only after the toggle settles, so it is stable
    always_comb
    begin
        c_next = c_reg;
        c_next.ext_s1 = f_reg.ext;
        c_next.ext_s2 = c_reg.ext_s1;
        c_next.tgl_s1 = f_reg.upd_tgl;
        c_next.tgl_s2 = c_reg.tgl_s1;
        c_next.tgl_s3 = c_reg.tgl_s2;
        if (c_reg.tgl_s2 != c_reg.tgl_s3)
            c_next.latch_cap = f_reg.latch;
        c_next.pin_out = c_reg.ext_s2 ? c_reg.latch_cap : CORE_OUT; // RULE_03
        c_next.pin_s1  = PIN_IN;
        c_next.pin_s2  = c_reg.pin_s1;
        c_next.core_in = c_reg.pin_s2; // RULE_05
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            c_reg           <= '0;
            c_reg.latch_cap <= jid_pkg::PIN_RESET;
            c_reg.pin_out   <= jid_pkg::PIN_RESET;
        end
        else
            c_reg <= c_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign TEST_DATA_OUT_PIN            = f_reg.tdo;
    assign TEST_DATA_OUT_OE             = f_reg.tdo_oe;
    assign PIN_OUT                      = c_reg.pin_out;
    assign CORE_IN                      = c_reg.core_in;
    assign TAP_CAPTURE_DR_ST            = r_reg.cap_dr;
    assign TAP_SHIFT_DR_ST              = r_reg.shf_dr;
    assign TAP_UPDATE_DR_ST             = r_reg.upd_dr;
    assign SEL_DEBUG_RECEIVE_ACCESS     = f_reg.sel[0];
    assign SEL_ICACHE_LOAD_ACCESS       = f_reg.sel[1];
    assign SEL_DEBUG_CTRL_STATUS_ACCESS = f_reg.sel[2];
    assign SEL_CORE_SELF_TEST           = f_reg.sel[3];
    assign SNAPSHOT_MODE_ENTRY          = f_reg.sel[4];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (!RST_N) // RULE_13
        r_reg.st == jid_pkg::TAP_CAPTURE_IR |=> r_reg.ir_sh == jid_pkg::IR_CAPTURE_PATTERN)
        else $error("Capture-IR did not load fixed pattern");

    AST_IR_UPDATE: assert property (@(negedge tck) disable iff (!RST_N) // RULE_14
        r_reg.st == jid_pkg::TAP_UPDATE_IR |=> f_reg.ir_cur == $past(r_reg.ir_sh))
        else $error("Update-IR did not latch the instruction");

    AST_LATCH_HOLD: assert property (@(negedge tck) disable iff (!RST_N) // RULE_15
        r_reg.st != jid_pkg::TAP_UPDATE_DR |=> $stable(f_reg.latch))
        else $error("Boundary latch changed outside Update-DR");

    AST_CHAIN_SHIFT: assert property (@(posedge tck) disable iff (!RST_N) // RULE_02
        (r_reg.st == jid_pkg::TAP_SHIFT_DR) && f_reg.ext && $stable(f_reg.ir_cur)
        |=> r_reg.bsr_sh == {$past(tdi), $past(r_reg.bsr_sh[15:1])})
        else $error("Boundary chain not in shift path under external test");

    AST_CAPTURE_PINS: assert property (@(posedge tck) disable iff (!RST_N) // RULE_04
        (r_reg.st == jid_pkg::TAP_CAPTURE_DR) && jid_is_chain(f_reg.ir_cur)
        |=> r_reg.bsr_sh[7:0] == $past(r_reg.pin_s2))
        else $error("Input pins not captured");

    AST_SNAPSHOT_CORE: assert property (@(posedge tck) disable iff (!RST_N) // RULE_06
        (r_reg.st == jid_pkg::TAP_CAPTURE_DR) &&
        (f_reg.ir_cur == jid_pkg::OP_PIN_SNAPSHOT_PRELOAD)
        |=> r_reg.bsr_sh[15:8] == $past(r_reg.core_s2))
        else $error("Core outputs not captured by snapshot");

    AST_PRELOAD_UPDATE: assert property (@(negedge tck) disable iff (!RST_N) // RULE_07
        (r_reg.st == jid_pkg::TAP_UPDATE_DR) &&
        (f_reg.ir_cur == jid_pkg::OP_PIN_SNAPSHOT_PRELOAD)
        |=> f_reg.latch == $past(r_reg.bsr_sh[15:8]))
        else $error("Preload did not reach output latches");

    AST_PIN_DRIVE: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_03
        c_reg.ext_s2 && $stable(c_reg.ext_s2) && $stable(c_reg.latch_cap)
        |=> PIN_OUT == $past(c_reg.latch_cap))
        else $error("Pins not driven from latches under external test");

    AST_CORE_ISOLATED: assert property (@(posedge CLK) disable iff (!RST_N) // RULE_05
        ##1 CORE_IN == $past(c_reg.pin_s2))
        else $error("Core input not taken from the pins");

    AST_SEL_DECODE: assert property (@(negedge tck) disable iff (!RST_N) // RULE_08
        SEL_DEBUG_RECEIVE_ACCESS == (f_reg.ir_cur == jid_pkg::OP_DEBUG_RECEIVE_ACCESS) &&
        SEL_ICACHE_LOAD_ACCESS == (f_reg.ir_cur == jid_pkg::OP_ICACHE_LOAD_ACCESS) && // RULE_09
        SEL_DEBUG_CTRL_STATUS_ACCESS == (f_reg.ir_cur == jid_pkg::OP_DEBUG_CTRL_STATUS) &&
        SEL_CORE_SELF_TEST == (f_reg.ir_cur == jid_pkg::OP_CORE_SELF_TEST) &&
        SNAPSHOT_MODE_ENTRY == (f_reg.ir_cur == jid_pkg::OP_SNAPSHOT_MODE_ENTRY))
        else $error("Core select does not match instruction"); // RULE_10 RULE_11 RULE_12

    AST_BYPASS: assert property (@(posedge tck) disable iff (!RST_N) // RULE_16
        (r_reg.st == jid_pkg::TAP_SHIFT_DR) && !jid_is_chain(f_reg.ir_cur) &&
        !jid_is_core(f_reg.ir_cur) |=> r_reg.byp == $past(tdi) && $stable(r_reg.bsr_sh))
        else $error("Reserved code did not bypass");

    AST_OE_SHIFT: assert property (@(negedge tck) disable iff (!RST_N) // RULE_02
        (r_reg.st == jid_pkg::TAP_SHIFT_IR) || (r_reg.st == jid_pkg::TAP_SHIFT_DR)
        |=> TEST_DATA_OUT_OE)
        else $error("Data out not enabled while shifting");

    AST_IR_SHIFT_OUT: assert property (@(negedge tck) disable iff (!RST_N) // RULE_13
        r_reg.st == jid_pkg::TAP_SHIFT_IR |=> TEST_DATA_OUT_PIN == $past(r_reg.ir_sh[0]))
        else $error("Instruction shifter not driving data out");

    AST_IR_RESET: assert property (@(negedge tck) disable iff (!RST_N) // RULE_16
        r_reg.st == jid_pkg::TAP_RESET |=> f_reg.ir_cur == jid_pkg::IR_RESET_VALUE)
        else $error("Controller reset did not select bypass");

    COV_EXTEST_UPDATE: cover property (@(negedge tck) disable iff (!RST_N)
        f_reg.ext && (r_reg.st == jid_pkg::TAP_UPDATE_DR));
    COV_IR_LOAD: cover property (@(negedge tck) disable iff (!RST_N)
        r_reg.st == jid_pkg::TAP_UPDATE_IR ##1 SNAPSHOT_MODE_ENTRY);
    COV_PIN_APPLY: cover property (@(posedge CLK) disable iff (!RST_N)
        c_reg.ext_s2 && (c_reg.tgl_s2 != c_reg.tgl_s3));
    COV_BYPASS_SHIFT: cover property (@(posedge tck) disable iff (!RST_N)
        (r_reg.st == jid_pkg::TAP_SHIFT_DR) && !jid_is_chain(f_reg.ir_cur) &&
        !jid_is_core(f_reg.ir_cur));
    COV_CHAIN_CAPTURE: cover property (@(posedge tck) disable iff (!RST_N)
        (r_reg.st == jid_pkg::TAP_CAPTURE_DR) && f_reg.ext);

endmodule

// ===== jid_pkg.sv
// Constants and types shared by the test-port instruction decoder
// Overview of operation
// [RULE_01] Seven-bit instruction codes: device, core, reserved
// [RULE_02] External test puts boundary chain in shift path
// [RULE_03] External test drives pins from boundary latches
// [RULE_04] External test captures input pins at capture
// [RULE_05] Shifted input cells never reach core logic
// [RULE_06] Snapshot captures pin and core values quietly
// [RULE_07] Preload update copies chain into output latches
// [RULE_08] Debug receive code selects core receive register
// [RULE_09] Icache load code selects cache load path
// [RULE_10] Control status code selects core debug register
// [RULE_11] Self test code selects core self test
// [RULE_12] Snapshot mode code puts core in snapshot
// [RULE_13] Capture-IR loads fixed pattern 0000001
// [RULE_14] Update-IR latches instruction on falling edge
// [RULE_15] Boundary latches change only in Update-DR
// [RULE_16] Reserved codes select one-bit bypass, no effect
package jid_pkg;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam int unsigned IR_W = 7;
    localparam logic [6:0] OP_EXTERNAL_PIN_TEST    = 7'h00;
    localparam logic [6:0] OP_PIN_SNAPSHOT_PRELOAD = 7'h01;
    localparam logic [6:0] OP_DEBUG_RECEIVE_ACCESS = 7'h02;
    localparam logic [6:0] OP_ICACHE_LOAD_ACCESS   = 7'h07;
    localparam logic [6:0] OP_DEBUG_CTRL_STATUS    = 7'h09;
    localparam logic [6:0] OP_CORE_SELF_TEST       = 7'h0A;
    localparam logic [6:0] OP_SNAPSHOT_MODE_ENTRY  = 7'h0C;
    localparam logic [6:0] IR_CAPTURE_PATTERN      = 7'h01;
    localparam logic [6:0] IR_RESET_VALUE          = 7'h7F;

    // ------------------------------------------------------------
    // Boundary chain layout: input cells low, output cells high
    // ------------------------------------------------------------
    localparam int unsigned NUM_IN  = 8;
    localparam int unsigned NUM_OUT = 8;
    localparam int unsigned BSR_LEN = NUM_IN + NUM_OUT;
    localparam logic [7:0]  PIN_RESET   = 8'h00;
    localparam logic [15:0] CHAIN_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Test access port states
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        TAP_RESET      = 16'h0001,
        TAP_IDLE       = 16'h0002,
        TAP_SEL_DR     = 16'h0004,
        TAP_CAPTURE_DR = 16'h0008,
        TAP_SHIFT_DR   = 16'h0010,
        TAP_EXIT1_DR   = 16'h0020,
        TAP_PAUSE_DR   = 16'h0040,
        TAP_EXIT2_DR   = 16'h0080,
        TAP_UPDATE_DR  = 16'h0100,
        TAP_SEL_IR     = 16'h0200,
        TAP_CAPTURE_IR = 16'h0400,
        TAP_SHIFT_IR   = 16'h0800,
        TAP_EXIT1_IR   = 16'h1000,
        TAP_PAUSE_IR   = 16'h2000,
        TAP_EXIT2_IR   = 16'h4000,
        TAP_UPDATE_IR  = 16'h8000
    } jid_tap_t;

endpackage

// ===== jid_tap_ctrl_model.sv
// Behavioural external test controller that drives the test port
`timescale 1ns/1ps
module jid_tap_ctrl_model
(
    // Test port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // ------------------------------------------------------------
    // Test clock stands low between frames
    // ------------------------------------------------------------
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // ------------------------------------------------------------
    // Cycle tasks
    // ------------------------------------------------------------
    // One 32 ns period; TDO taken just before the rising edge
    // Ends 1 ns after the fall, so callers read settled outputs
    task automatic cycle(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #15;
        q = tdo;
        tck = 1'b1;
        #16;
        tck = 1'b0;
        #1;
    endtask

    // Data line toggles outside shifts, so stale bits never look valid
    task automatic step(input logic m);
        logic q;
        cycle(m, ~tdi, q);
    endtask

    // From Idle: scan n bits LSB first; hold parks the port in Pause
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout, input logic hold);
        logic q;
        dout = 16'h0000;
        step(1'b1);
        if (ir)
            step(1'b1);
        step(1'b0);
        step(1'b0);
        for (int i = 0; i < n; i++)
        begin
            cycle(i == n - 1, din[i], q);
            dout[i] = q;
        end
        if (hold)
            step(1'b0);
        else
            leave(1'b0);
    endtask

    // Through Update back to Idle, from Exit1 or from Pause
    task automatic leave(input logic paused);
        if (paused)
            step(1'b1);
        step(1'b1);
        step(1'b0);
    endtask

    // Five high mode-select edges force Test-Logic-Reset, then Idle
    task automatic reset_tap();
        repeat (5) step(1'b1);
        step(1'b0);
    endtask
endmodule

// ===== jid_instr_decode_tb_top.sv
// Self-checking bench for the test-port instruction decoder
`timescale 1ns/1ps
module jid_instr_decode_tb_top;
    logic       clk;
    logic       rst_n;
    logic       tck;
    logic       tms;
    logic       tdi;
    logic       tdo;
    logic       tdo_oe;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] core_out;
    logic [7:0] core_in;
    logic       core_so;
    logic [4:0] sels;
    logic [2:0] dr_flags;
    logic [15:0] d;
    int         bad_count;
    int         checks_done;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    jid_instr_decode jid_instr_decode_inst (
        .CLK(clk), .RST_N(rst_n), .TEST_CLOCK_PIN(tck), .TEST_MODE_SELECT_PIN(tms),
        .TEST_DATA_IN_PIN(tdi), .TEST_DATA_OUT_PIN(tdo), .TEST_DATA_OUT_OE(tdo_oe),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .CORE_OUT(core_out), .CORE_IN(core_in),
        .CORE_TDR_SO(core_so), .TAP_CAPTURE_DR_ST(dr_flags[0]), .TAP_SHIFT_DR_ST(dr_flags[1]),
        .TAP_UPDATE_DR_ST(dr_flags[2]), .SEL_DEBUG_RECEIVE_ACCESS(sels[0]),
        .SEL_ICACHE_LOAD_ACCESS(sels[1]), .SEL_DEBUG_CTRL_STATUS_ACCESS(sels[2]),
        .SEL_CORE_SELF_TEST(sels[3]), .SNAPSHOT_MODE_ENTRY(sels[4]));
    jid_tap_ctrl_model jid_tap_ctrl_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Step off the edge so registered outputs have settled
    task automatic clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic load_ir(input logic [6:0] code, input logic hold);
        jid_tap_ctrl_model_inst.scan(1'b1, 7, {9'h000, code}, d, hold);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        compare("oe idle", 16'h0000, {15'h0000, tdo_oe});
        compare("selects", 16'h0000, {11'h000, sels});
        compare("pin out", {8'h00, core_out}, {8'h00, pin_out});
        compare("core in", {8'h00, pin_in}, {8'h00, core_in});
        jid_tap_ctrl_model_inst.reset_tap();
        load_ir(7'h03, 1'b0);
        compare("ir capture", {9'h000, jid_pkg::IR_CAPTURE_PATTERN}, d);
        $display("test reset done");
    endtask

    task automatic test_decode();
        logic [6:0] codes [7];
        codes = '{jid_pkg::OP_DEBUG_RECEIVE_ACCESS, jid_pkg::OP_ICACHE_LOAD_ACCESS,
                  jid_pkg::OP_DEBUG_CTRL_STATUS, jid_pkg::OP_CORE_SELF_TEST,
                  jid_pkg::OP_SNAPSHOT_MODE_ENTRY, 7'h03, 7'h7F};
        load_ir(codes[0], 1'b1);
        compare("select before update", 16'h0000, {11'h000, sels});
        jid_tap_ctrl_model_inst.leave(1'b1);
        compare("select after update", 16'h0001, {11'h000, sels});
        for (int i = 0; i < 7; i++)
        begin
            load_ir(codes[i], 1'b0);
            compare("select", (i < 5) ? 16'h0001 << i : 16'h0000, {11'h000, sels});
            jid_tap_ctrl_model_inst.scan(1'b0, 8, 16'h00A5, d, 1'b0);
            compare("data path", (i < 5) ? 16'h00FF : 16'h004A, d);
            compare("oe idle", 16'h0000, {15'h0000, tdo_oe});
        end
        jid_tap_ctrl_model_inst.step(1'b1);
        jid_tap_ctrl_model_inst.step(1'b0);
        compare("capture flag", 16'h0001, {13'h0000, dr_flags});
        jid_tap_ctrl_model_inst.step(1'b0);
        compare("shift flag", 16'h0002, {13'h0000, dr_flags});
        compare("oe shift", 16'h0001, {15'h0000, tdo_oe});
        repeat (2) jid_tap_ctrl_model_inst.step(1'b1);
        compare("update flag", 16'h0004, {13'h0000, dr_flags});
        jid_tap_ctrl_model_inst.step(1'b0);
        compare("idle flags", 16'h0000, {13'h0000, dr_flags});
        $display("test decode done");
    endtask

    task automatic test_preload();
        @(posedge clk);
        pin_in <= 8'h3C;
        core_out <= 8'hC5;
        clks(4);
        load_ir(jid_pkg::OP_PIN_SNAPSHOT_PRELOAD, 1'b0);
        jid_tap_ctrl_model_inst.scan(1'b0, 16, 16'h965A, d, 1'b0);
        compare("snapshot", 16'hC53C, d);
        clks(10);
        compare("pin out", 16'h00C5, {8'h00, pin_out});
        compare("core in", 16'h003C, {8'h00, core_in});
        $display("test preload done");
    endtask

    task automatic test_extest();
        load_ir(jid_pkg::OP_EXTERNAL_PIN_TEST, 1'b0);
        clks(10);
        compare("preloaded pins", 16'h0096, {8'h00, pin_out});
        @(posedge clk);
        core_out <= 8'h11;
        clks(10);
        compare("pins from latch", 16'h0096, {8'h00, pin_out});
        repeat (2) jid_tap_ctrl_model_inst.step(1'b0);
        jid_tap_ctrl_model_inst.scan(1'b0, 16, 16'h69FF, d, 1'b1);
        compare("chain capture", 16'h113C, d);
        clks(10);
        compare("pins while paused", 16'h0096, {8'h00, pin_out});
        jid_tap_ctrl_model_inst.leave(1'b1);
        clks(10);
        compare("pins after update", 16'h0069, {8'h00, pin_out});
        compare("core in", 16'h003C, {8'h00, core_in});
        jid_tap_ctrl_model_inst.reset_tap();
        clks(10);
        compare("pins after tap reset", 16'h0011, {8'h00, pin_out});
        $display("test extest done");
    endtask

    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial
    begin
        bad_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        pin_in = 8'h00;
        core_out = 8'h5A;
        core_so = 1'b1;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        clks(6);
        test_reset();
        test_decode();
        test_preload();
        test_extest();
        wrap_up();
    end

    // Whole run needs well under 20 us
    initial
    begin
        #100us;
        bad_count++;
        wrap_up();
    end
endmodule
